// ### logic/control_channel_error_config.sv
// Configuration register and error handling of the bidirectional control channel.
// Assumes register accesses and link events arrive on core_clk_i from internal logic.
//
// Overview of operation
// (R1) Configuration register at 0x6E resets to 0x20: remote blocked, checks off.
// (R2) Bit 5 set refuses remote forwarding; local register accesses still served.
// (R3) Bit 4 set aborts the active transaction on a back channel CRC error.
// (R4) Abort on error does nothing while enhanced checking (bit 0) is clear.
// (R5) Bit 2 set gives an early internal acknowledge at each remote read start.
// (R6) Bit 1 set compares echoed write data; mismatch turns remote ACK into NACK.
// (R7) Bit 0 enables termination on error; clear blocks aborts, error detection still runs.
// (R8) Returned byte checked per write frame; error sets a flag cleared on status read.
`default_nettype none

module control_channel_error_config
  import cc_err_pkg::*;
(
  input  wire logic                  core_clk_i,    // Core clock, 20 MHz
  input  wire logic                  rst_i,         // Async reset, active high
  input  wire logic [7:0]            reg_addr_i,    // Register offset
  input  wire logic                  reg_wr_i,      // Register write strobe
  input  wire logic                  reg_rd_i,      // Register read strobe
  input  wire logic [7:0]            reg_wdata_i,   // Register write data
  output logic      [7:0]            reg_rdata_o,   // Register read data
  input  wire logic                  req_valid_i,   // New transaction request
  input  wire cc_err_pkg::xact_req_s req_i,         // Request details
  input  wire logic                  resp_valid_i,  // Response frame received
  input  wire cc_err_pkg::link_resp_s resp_i,       // Response contents
  input  wire logic                  bc_crc_err_i,  // Back channel CRC error
  output logic                       busy_o,        // Remote transaction open
  output logic                       fwd_start_o,   // Forward to remote side
  output logic                       local_start_o, // Serve local registers
  output logic                       refuse_o,      // Remote access refused
  output logic                       early_ack_o,   // Early read acknowledge
  output logic                       abort_o,       // Transaction terminated
  output logic                       ans_valid_o,   // Local bus answer ready
  output logic                       ans_ack_o      // 1 ACK, 0 NACK
);

  import cc_err_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  cfg_reg;
  logic        resp_err_reg;
  chan_state_e state_reg;
  logic [7:0]  sent_data_reg;
  logic        sent_read_reg;

  logic blocked;
  logic abort_en;
  logic accept;
  logic abort_cond;
  logic resp_take;
  logic mismatch;
  logic resp_err_set;
  logic status_rd;

  assign blocked      = cfg_reg[BLOCK_BIT];
  assign abort_en     = cfg_reg[ABORT_BIT] & cfg_reg[ENH_BIT];  // R4 R7
  assign accept       = req_valid_i && (state_reg == ST_IDLE);
  assign abort_cond   = (state_reg == ST_WAIT) && bc_crc_err_i && abort_en;  // R3
  assign resp_take    = (state_reg == ST_WAIT) && resp_valid_i && !abort_cond;
  assign mismatch     = !sent_read_reg && (resp_i.data != sent_data_reg);  // R8
  assign resp_err_set = resp_take && mismatch;
  assign status_rd    = reg_rd_i && (reg_addr_i == STATUS_ADDR);
  assign busy_o       = (state_reg == ST_WAIT);

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cfg_reg <= CFG_RESET;  // R1
    else if (reg_wr_i && (reg_addr_i == CFG_ADDR))
      cfg_reg <= reg_wdata_i & CFG_WMASK;
  end

  // Set wins over read clear
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      resp_err_reg <= 1'b0;
    else if (resp_err_set)
      resp_err_reg <= 1'b1;  // R8
    else if (status_rd)
      resp_err_reg <= 1'b0;  // R8
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_o <= STATUS_ZERO;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        CFG_ADDR:    reg_rdata_o <= cfg_reg;  // R1
        STATUS_ADDR: reg_rdata_o <= {7'h0, resp_err_reg};  // R8
        default:     reg_rdata_o <= STATUS_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transaction tracking
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_reg <= ST_IDLE;
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (accept && req_i.remote && !blocked)
            state_reg <= ST_WAIT;  // R2
        ST_WAIT:
          if (abort_cond || resp_valid_i)
            state_reg <= ST_IDLE;  // R3
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sent_data_reg <= STATUS_ZERO;
      sent_read_reg <= 1'b0;
    end
    else if (accept)
    begin
      sent_data_reg <= req_i.data;
      sent_read_reg <= req_i.read;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fwd_start_o   <= 1'b0;
      local_start_o <= 1'b0;
      refuse_o      <= 1'b0;
      early_ack_o   <= 1'b0;
    end
    else
    begin
      fwd_start_o   <= accept && req_i.remote && !blocked;  // R2
      local_start_o <= accept && !req_i.remote;  // R2
      refuse_o      <= accept && req_i.remote && blocked;  // R2
      early_ack_o   <= accept && req_i.remote && !blocked && req_i.read
                       && cfg_reg[EARLY_ACK_BIT];  // R5
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      abort_o     <= 1'b0;
      ans_valid_o <= 1'b0;
      ans_ack_o   <= 1'b0;
    end
    else
    begin
      abort_o     <= abort_cond;  // R3
      ans_valid_o <= resp_take;
      if (resp_take)
        ans_ack_o <= resp_i.ack && !(cfg_reg[DATA_CHK_BIT] && mismatch);  // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_cfg_write_read: assert property ( // R1
    reg_wr_i && reg_addr_i == CFG_ADDR ##1 reg_rd_i && reg_addr_i == CFG_ADDR
    && !reg_wr_i |=> reg_rdata_o == ($past(reg_wdata_i, 2) & CFG_WMASK))
    else $error("config readback differs from write");

  a_remote_refused: assert property ( // R2
    accept && req_i.remote && blocked |=> refuse_o && !fwd_start_o && !busy_o)
    else $error("remote access not refused while blocked");

  a_local_served: assert property ( // R2
    accept && !req_i.remote |=> local_start_o && !refuse_o)
    else $error("local access not served");

  a_abort_on_crc: assert property ( // R3
    busy_o && bc_crc_err_i && cfg_reg[ABORT_BIT] && cfg_reg[ENH_BIT]
    |=> abort_o && !busy_o && !ans_valid_o)
    else $error("transaction not aborted on crc error");

  a_abort_gated_enh: assert property ( // R4
    busy_o && bc_crc_err_i && !cfg_reg[ENH_BIT] |=> !abort_o)
    else $error("abort while enhanced checking off");

  a_abort_needs_enh: assert property ( // R7
    abort_o |-> $past(cfg_reg[ENH_BIT]) && $past(busy_o))
    else $error("abort without enhanced checking");

  a_early_read_ack: assert property ( // R5
    accept && req_i.remote && !blocked && req_i.read && cfg_reg[EARLY_ACK_BIT]
    |=> early_ack_o && fwd_start_o)
    else $error("early read acknowledge missing");

  a_data_mismatch_nack: assert property ( // R6
    resp_take && !sent_read_reg && cfg_reg[DATA_CHK_BIT]
    && resp_i.data != sent_data_reg |=> ans_valid_o && !ans_ack_o)
    else $error("data mismatch not turned into nack");

  a_resp_flag_set: assert property ( // R8
    resp_err_set |=> resp_err_reg)
    else $error("response error flag not set");

  a_flag_read_clear: assert property ( // R8
    status_rd && !resp_err_set |=> !resp_err_reg
    && reg_rdata_o[RESP_ERR_BIT] == $past(resp_err_reg))
    else $error("status read did not clear flag");

endmodule : control_channel_error_config

`default_nettype wire

// ### logic/cc_err_pkg.sv
// Constants and carriers for the control channel error configuration block.
// Assumes a single core clock domain shared with the register access logic.
`default_nettype none

package cc_err_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] CFG_ADDR    = 8'h6E;
  localparam logic [7:0] STATUS_ADDR = 8'h6D;
  localparam logic [7:0] CFG_RESET   = 8'h20;
  localparam logic [7:0] CFG_WMASK   = 8'h3F;
  localparam logic [7:0] STATUS_ZERO = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BLOCK_BIT     = 5;
  localparam int ABORT_BIT     = 4;
  localparam int EARLY_ACK_BIT = 2;
  localparam int DATA_CHK_BIT  = 1;
  localparam int ENH_BIT       = 0;
  localparam int RESP_ERR_BIT  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       remote;  // Targets a device beyond the link
    logic       read;    // Read transaction
    logic [7:0] data;    // Byte sent in the forward frame
  } xact_req_s;

  typedef struct packed {
    logic       ack;     // Remote acknowledge
    logic [7:0] data;    // Byte echoed back by the far end
  } link_resp_s;

  typedef enum {
    ST_IDLE,
    ST_WAIT
  } chan_state_e;

endpackage : cc_err_pkg

`default_nettype wire

// ### sim/far_end_model.sv
// Far end model: echoes each forwarded byte after a set delay.
// Assumes the sent byte stays on data_i until the echo returns.
`default_nettype none

module far_end_model
  import cc_err_pkg::*;
(
  input  wire logic              core_clk_i,   // Core clock
  input  wire logic              rst_i,        // Async reset
  input  wire logic              fwd_i,        // Forward frame start
  input  wire logic [7:0]        data_i,       // Byte sent
  input  wire logic [7:0]        dly_i,        // Echo delay in cycles
  input  wire logic              bad_i,        // Corrupt the echo
  output logic                   resp_valid_o, // Response frame
  output cc_err_pkg::link_resp_s resp_o        // Response contents
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_reg;

  always_ff @(negedge core_clk_i or posedge rst_i)
    if (rst_i)
    begin
      cnt_reg <= 8'h00;
      resp_valid_o <= 1'b0;
      resp_o <= '0;
    end
    else
    begin
      if (fwd_i)
        cnt_reg <= dly_i;
      else if (cnt_reg != 8'h00)
        cnt_reg <= cnt_reg - 8'h01;
      resp_valid_o <= (cnt_reg == 8'h01);
      resp_o.ack <= (cnt_reg == 8'h01);
      // Stale data is inverted so it never passes for an echo
      resp_o.data <= (cnt_reg == 8'h01) ? (data_i ^ {7'h00, bad_i}) : ~resp_o.data;
    end
endmodule : far_end_model

`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the control channel error configuration block.
// Assumes the far end model answers forwarded frames.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cc_err_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rv = 1'b0, crc = 1'b0, bad = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, dly = 8'h02, rdata;
  xact_req_s req = '0;
  link_resp_s resp;
  logic rvld, busy, fwd, loc, refuse, eack, abort, avld, aack;
  int fails = 0, compares = 0, cyc = 0;

  control_channel_error_config i_dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .req_valid_i(rv), .req_i(req), .resp_valid_i(rvld), .resp_i(resp),
    .bc_crc_err_i(crc), .busy_o(busy), .fwd_start_o(fwd), .local_start_o(loc),
    .refuse_o(refuse), .early_ack_o(eack), .abort_o(abort), .ans_valid_o(avld),
    .ans_ack_o(aack));
  far_end_model i_far (.core_clk_i(clk), .rst_i(rst), .fwd_i(fwd), .data_i(req.data),
    .dly_i(dly), .bad_i(bad), .resp_valid_o(rvld), .resp_o(resp));

  initial
    forever #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic rg(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
  endtask : rg

  task automatic go(input logic m, input logic r, input logic [7:0] d);
    @(negedge clk);
    rv = 1'b1;
    req = '{remote: m, read: r, data: d};
    @(negedge clk);
    rv = 1'b0;
  endtask : go

  task automatic ans(input logic e);
    int i;
    i = 0;
    while (avld !== 1'b1 && i < 20)
    begin
      @(negedge clk);
      i++;
    end
    chk("ans_valid", 8'(avld), 8'h01);
    chk("ans_ack", 8'(aack), 8'(e));
  endtask : ans

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rg(1'b0, CFG_ADDR, 8'h00);
    chk("cfg", rdata, CFG_RESET);
    rg(1'b0, STATUS_ADDR, 8'h00);
    chk("status", rdata, STATUS_ZERO);
    rg(1'b0, 8'h55, 8'h00);
    chk("unmapped", rdata, 8'h00);
  endtask : t_reset

  task automatic t_block;
    go(1'b1, 1'b0, 8'hA5);
    chk("refuse", 8'(refuse), 8'h01);
    chk("fwd", 8'(fwd), 8'h00);
    go(1'b0, 1'b0, 8'h00);
    chk("local", 8'(loc), 8'h01);
    // Write then read back to back
    @(negedge clk);
    wr = 1'b1;
    addr = CFG_ADDR;
    wdata = 8'hFF;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk("cfg_wr", rdata, CFG_WMASK);
  endtask : t_block

  task automatic t_data;
    // Unblock remote, enable early ack, data check and enhanced checking
    rg(1'b1, CFG_ADDR, 8'h07);
    go(1'b1, 1'b0, 8'h3C);
    chk("fwd", 8'(fwd), 8'h01);
    ans(1'b1);
    bad = 1'b1;
    go(1'b1, 1'b0, 8'hC3);
    ans(1'b0);
    bad = 1'b0;
    rg(1'b0, STATUS_ADDR, 8'h00);
    chk("flag", rdata, 8'h01);
    rg(1'b0, STATUS_ADDR, 8'h00);
    chk("flag_clr", rdata, 8'h00);
  endtask : t_data

  task automatic t_early;
    go(1'b1, 1'b1, 8'h00);
    chk("early", 8'(eack), 8'h01);
    ans(1'b1);
    rg(1'b1, CFG_ADDR, 8'h01);
    go(1'b1, 1'b1, 8'h00);
    chk("no_early", 8'(eack), 8'h00);
    ans(1'b1);
  endtask : t_early

  task automatic t_abort(input logic [7:0] c, input logic e);
    rg(1'b1, CFG_ADDR, c);
    dly = 8'h06;
    go(1'b1, 1'b0, 8'h11);
    crc = 1'b1;
    @(negedge clk);
    crc = 1'b0;
    chk("abort", 8'(abort), 8'(e));
    chk("busy", 8'(busy), 8'(!e));
    if (!e)
      ans(1'b1);
    repeat (10) @(negedge clk);
  endtask : t_abort

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      summarize();
    end
  end

  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_block();
    t_data();
    t_early();
    t_abort(8'h11, 1'b1);
    t_abort(8'h10, 1'b0);
    summarize();
  end
endmodule : testbench

`default_nettype wire
